// [hdl/ptc_capture.sv]
// Position trigger capture with two-deep holding store and Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none

module ptc_capture (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [ptc_pkg::AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [ptc_pkg::DW-1:0] avs_writedata_i,
    output logic [ptc_pkg::DW-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Position source and scale signals, same clock
    input wire logic [ptc_pkg::DW-1:0] position_i,
    input wire logic ref_mark_i,
    input wire logic sync_error_i,
    // External trigger pin, asynchronous
    input wire logic trigger_input_i,
    // Status outputs
    output logic pin_trigger_flag_o,
    output logic timer_trigger_flag_o,
    output logic reference_trigger_flag_o,
    output logic trigger_overflow_flag_o,
    output logic reference_sync_flag_o,
    output logic irq_o
);
    localparam logic [1:0] DEPTH_C = 2'(ptc_pkg::DEPTH);

    logic trg_s1_q, trg_s2_q, trg_s3_q;
    logic [ptc_pkg::TPW-1:0] tim_cnt_q, tim_cnt_d, tper_q;
    logic [2:0] ctrl_q;
    logic [ptc_pkg::IW-1:0] ist_q, ist_d, imsk_q, ist_clr_q, ist_ev;
    logic [ptc_pkg::DW-1:0] rdata_q;
    logic wait_q, pop_q, ovl_clr_q, ovl_q, sync_q, sync_d, irq_q;
    logic [2:0] flags_q;
    logic [1:0] cnt_q, cnt_d, cnt_after;
    ptc_pkg::ptc_entry_s ent_q [ptc_pkg::DEPTH];
    ptc_pkg::ptc_entry_s ent_d [ptc_pkg::DEPTH];
    ptc_pkg::ptc_entry_s new_ent;

    // Trigger pin synchroniser; edge detect reads only the second stage onward
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            trg_s1_q <= 1'b0;
            trg_s2_q <= 1'b0;
            trg_s3_q <= 1'b0;
        end else begin
            trg_s1_q <= trigger_input_i;
            trg_s2_q <= trg_s1_q;
            trg_s3_q <= trg_s2_q;
        end
    end

    // Event sources
    wire pin_ev = ctrl_q[ptc_pkg::CTRL_PIN_EN] & trg_s2_q & ~trg_s3_q;
    wire tim_run = ctrl_q[ptc_pkg::CTRL_TIM_EN] & (tper_q != '0);
    wire tim_wrap = tim_cnt_q >= tper_q - 16'h0001;
    wire tim_ev = tim_run & tim_wrap;
    wire ref_ev = ctrl_q[ptc_pkg::CTRL_REF_EN] & ref_mark_i;
    wire any_ev = pin_ev | tim_ev | ref_ev;
    assign tim_cnt_d = (!tim_run || tim_wrap) ? '0 : tim_cnt_q + 16'h0001;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) tim_cnt_q <= '0;
        else tim_cnt_q <= tim_cnt_d;
    end

    // Bus decode: one wait cycle, then the access completes
    wire req = avs_read_i | avs_write_i;
    wire first = req & wait_q;
    wire accept = req & ~wait_q;
    wire wr = avs_write_i & accept;
    wire rd_meas = avs_read_i & first & (avs_address_i == ptc_pkg::OFS_MEAS);
    wire rd_stat = avs_read_i & first & (avs_address_i == ptc_pkg::OFS_STAT);
    wire rd_ist = avs_read_i & first & (avs_address_i == ptc_pkg::OFS_IST);
    wire pop = accept & pop_q;

    // Holding store; entry 0 is the oldest
    wire full_block = (cnt_q == DEPTH_C) & ~pop;
    wire push = any_ev & ~full_block;
    wire ovl_ev = any_ev & full_block;
    // Coincident sources capture the same count, so all their flags are kept
    assign new_ent = '{value: position_i, src: {ref_ev, tim_ev, pin_ev}};
    assign cnt_after = cnt_q - {1'b0, pop};
    assign cnt_d = cnt_after + {1'b0, push};

    generate
        for (genvar i = 0; i < ptc_pkg::DEPTH; i++) begin : g_ent
            ptc_pkg::ptc_entry_s shifted;
            if (i + 1 < ptc_pkg::DEPTH) begin : g_sh
                assign shifted = pop ? ent_q[i+1] : ent_q[i];
            end else begin : g_last
                assign shifted = ent_q[i];
            end
            assign ent_d[i] = (push && cnt_after == 2'(i)) ? new_ent : shifted;
            always_ff @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) ent_q[i] <= '0;
                else ent_q[i] <= ent_d[i];
            end
        end
    endgenerate

    // Reference sync: an error in the same cycle as the mark wins
    assign sync_d = sync_error_i ? 1'b0 : (ref_mark_i ? 1'b1 : sync_q);

    assign ist_ev[ptc_pkg::IRQ_CAP] = push;
    assign ist_ev[ptc_pkg::IRQ_OVL] = ovl_ev;
    assign ist_ev[ptc_pkg::IRQ_GAIN] = sync_d & ~sync_q;
    assign ist_ev[ptc_pkg::IRQ_LOST] = sync_q & ~sync_d;
    // Only bits seen by the read are cleared, and a new event wins
    assign ist_d = (ist_q & ~(accept ? ist_clr_q : '0)) | ist_ev;

    // Read mux, sampled in the wait cycle
    wire [ptc_pkg::DW-1:0] meas_val = (cnt_q != '0) ? ent_q[0].value : position_i;
    wire [ptc_pkg::DW-1:0] stat_val = {27'h0, sync_q, ovl_q, flags_q};
    logic [ptc_pkg::DW-1:0] rmux;
    always_comb begin
        case (avs_address_i)
            ptc_pkg::OFS_MEAS: rmux = meas_val;
            ptc_pkg::OFS_POS: rmux = position_i;
            ptc_pkg::OFS_STAT: rmux = stat_val;
            ptc_pkg::OFS_IST: rmux = {28'h0000000, ist_q};
            ptc_pkg::OFS_IMSK: rmux = {28'h0000000, imsk_q};
            ptc_pkg::OFS_CTRL: rmux = {29'h0, ctrl_q};
            ptc_pkg::OFS_TPER: rmux = {16'h0000, tper_q};
            default: rmux = '0;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
            pop_q <= 1'b0;
            ovl_clr_q <= 1'b0;
            ist_clr_q <= '0;
        end else begin
            wait_q <= ~first;
            if (first) rdata_q <= avs_read_i ? rmux : '0;
            // Pop decided when the data is sampled, so a late push is not lost
            if (first) pop_q <= rd_meas & (cnt_q != '0);
            if (first) ovl_clr_q <= rd_stat & ovl_q;
            if (first) ist_clr_q <= rd_ist ? ist_q : '0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= ptc_pkg::CTRL_RST;
            imsk_q <= ptc_pkg::IMSK_RST;
            tper_q <= ptc_pkg::TPER_RST;
        end else if (wr) begin
            if (avs_address_i == ptc_pkg::OFS_CTRL) ctrl_q <= avs_writedata_i[2:0];
            if (avs_address_i == ptc_pkg::OFS_IMSK) imsk_q <= avs_writedata_i[ptc_pkg::IW-1:0];
            if (avs_address_i == ptc_pkg::OFS_TPER) tper_q <= avs_writedata_i[ptc_pkg::TPW-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            flags_q <= '0;
            ovl_q <= 1'b0;
            sync_q <= 1'b0;
            ist_q <= '0;
            irq_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            flags_q <= (cnt_d != '0) ? ent_d[0].src : 3'h0;
            ovl_q <= ovl_ev | (ovl_q & ~(accept & ovl_clr_q));
            sync_q <= sync_d;
            ist_q <= ist_d;
            irq_q <= |(ist_d & imsk_q);
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;
    assign pin_trigger_flag_o = flags_q[ptc_pkg::SRC_PIN];
    assign timer_trigger_flag_o = flags_q[ptc_pkg::SRC_TIM];
    assign reference_trigger_flag_o = flags_q[ptc_pkg::SRC_REF];
    assign trigger_overflow_flag_o = ovl_q;
    assign reference_sync_flag_o = sync_q;
    assign irq_o = irq_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    pin_flag_a: assert property (
        cnt_q == 2'h0 && pin_ev |=> pin_trigger_flag_o && cnt_q == 2'h1)
        else $error("pin capture did not raise pin flag");
    timer_flag_a: assert property (
        cnt_q == 2'h0 && tim_ev && !pin_ev && !ref_ev |=> timer_trigger_flag_o
            && !pin_trigger_flag_o && !reference_trigger_flag_o)
        else $error("timer capture flag wrong");
    ref_flag_a: assert property (
        cnt_q == 2'h0 && ref_ev |=> reference_trigger_flag_o)
        else $error("reference capture did not raise flag");
    live_read_a: assert property (
        rd_meas && cnt_q == 2'h0 |=> avs_readdata_o == $past(position_i))
        else $error("empty store read did not return live count");
    depth_max_a: assert property (
        cnt_q <= DEPTH_C && (cnt_q == 2'h0 || flags_q != 3'h0))
        else $error("store depth or flags inconsistent");
    overflow_lost_a: assert property (
        any_ev && cnt_q == DEPTH_C && !pop |=> trigger_overflow_flag_o && cnt_q == DEPTH_C)
        else $error("overflow not flagged or event kept");
    sync_gain_a: assert property (
        ref_mark_i && !sync_error_i |=> reference_sync_flag_o)
        else $error("sync flag not set by reference mark");
    sync_lost_a: assert property (
        sync_error_i ##1 !ref_mark_i [*2] |-> !reference_sync_flag_o)
        else $error("sync flag not held clear after error");
    pop_oldest_a: assert property (
        pop && !any_ev && cnt_q == 2'h2 |=> cnt_q == 2'h1
            && flags_q == $past(ent_q[1].src))
        else $error("read did not advance to next pending value");
    bus_answer_a: assert property (
        first |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer timing wrong");

    // Source flags, holding store, overflow, sync, interrupts and bus registers
    pin_only_a: assert property (
        cnt_q == 2'h0 && pin_ev && !tim_ev && !ref_ev |=> pin_trigger_flag_o
            && !timer_trigger_flag_o && !reference_trigger_flag_o)
        else $error("pin-only capture flags wrong");
    ref_only_a: assert property (
        cnt_q == 2'h0 && ref_ev && !pin_ev && !tim_ev |=> reference_trigger_flag_o
            && !timer_trigger_flag_o && !pin_trigger_flag_o)
        else $error("reference-only capture flags wrong");
    head_after_pop_a: assert property (
        cnt_q == 2'h1 && pop && tim_ev && !pin_ev && !ref_ev |=> timer_trigger_flag_o
            && !pin_trigger_flag_o && cnt_q == 2'h1)
        else $error("timer capture during pop not at head");
    pin_stands_a: assert property (
        pin_trigger_flag_o && !pop |=> pin_trigger_flag_o)
        else $error("pin flag dropped without a read");
    timer_stands_a: assert property (
        timer_trigger_flag_o && !pop |=> timer_trigger_flag_o)
        else $error("timer flag dropped without a read");
    ref_stands_a: assert property (
        reference_trigger_flag_o && !pop |=> reference_trigger_flag_o)
        else $error("reference flag dropped without a read");
    flags_clear_a: assert property (
        cnt_q == 2'h1 && pop && !any_ev |=> !pin_trigger_flag_o
            && !timer_trigger_flag_o && !reference_trigger_flag_o)
        else $error("flags left set with empty store");
    meas_head_a: assert property (
        rd_meas && cnt_q != 2'h0 |=> avs_readdata_o == $past(ent_q[0].value))
        else $error("measured read did not return oldest value");
    full_hold_a: assert property (
        cnt_q == DEPTH_C && !pop |=> ent_q[1].value == $past(ent_q[1].value))
        else $error("full store entry overwritten");
    ovl_sticky_a: assert property (
        trigger_overflow_flag_o && !(accept && ovl_clr_q) |=> trigger_overflow_flag_o)
        else $error("overflow flag not sticky");
    ovl_cause_a: assert property (
        !trigger_overflow_flag_o && !ovl_ev |=> !trigger_overflow_flag_o)
        else $error("overflow flag set without a lost event");
    full_swap_a: assert property (
        any_ev && cnt_q == DEPTH_C && pop && !trigger_overflow_flag_o
            |=> !trigger_overflow_flag_o && cnt_q == DEPTH_C)
        else $error("event with pop on full store was lost");
    sync_hold_a: assert property (
        reference_sync_flag_o && !sync_error_i |=> reference_sync_flag_o)
        else $error("sync flag dropped without error");
    sync_error_a: assert property (
        sync_error_i |=> !reference_sync_flag_o)
        else $error("sync flag kept after error");
    sync_stay_a: assert property (
        !reference_sync_flag_o && !ref_mark_i |=> !reference_sync_flag_o)
        else $error("sync flag set without reference mark");
    gain_irq_a: assert property (
        $rose(reference_sync_flag_o) |-> ist_q[ptc_pkg::IRQ_GAIN])
        else $error("sync gain status not set");
    lost_irq_a: assert property (
        $fell(reference_sync_flag_o) |-> ist_q[ptc_pkg::IRQ_LOST])
        else $error("sync lost status not set");
    cap_irq_a: assert property (
        push |=> ist_q[ptc_pkg::IRQ_CAP])
        else $error("capture status not set");
    ovl_irq_a: assert property (
        ovl_ev |=> ist_q[ptc_pkg::IRQ_OVL])
        else $error("overflow status not set");
    irq_level_a: assert property (
        $stable(imsk_q) |-> irq_o == |(ist_q & imsk_q))
        else $error("interrupt level wrong");
    wait_idle_a: assert property (
        !avs_read_i && !avs_write_i |=> avs_waitrequest_o)
        else $error("waitrequest low while idle");
    tper_write_a: assert property (
        wr && avs_address_i == ptc_pkg::OFS_TPER |=> tper_q == $past(avs_writedata_i[15:0]))
        else $error("timer period write lost");
    ctrl_write_a: assert property (
        wr && avs_address_i == ptc_pkg::OFS_CTRL |=> ctrl_q == $past(avs_writedata_i[2:0]))
        else $error("control write lost");
    imsk_write_a: assert property (
        wr && avs_address_i == ptc_pkg::OFS_IMSK |=> imsk_q == $past(avs_writedata_i[3:0]))
        else $error("mask write lost");
    unmapped_read_a: assert property (
        avs_read_i && first && avs_address_i > ptc_pkg::OFS_TPER |=> avs_readdata_o == '0)
        else $error("unmapped read not zero");
    stat_read_a: assert property (
        rd_stat |=> avs_readdata_o[ptc_pkg::DW-1:5] == '0
            && avs_readdata_o[ptc_pkg::ST_SYNC] == $past(reference_sync_flag_o)
            && avs_readdata_o[ptc_pkg::ST_OVL] == $past(trigger_overflow_flag_o))
        else $error("status read layout wrong");
    timer_period_a: assert property (
        tim_ev && tper_q > 16'h0001 && !wr |=> !tim_ev)
        else $error("timer ticked twice in a row");
    pop_has_data_a: assert property (
        pop |-> cnt_q != 2'h0)
        else $error("pop from empty store");
    meas_pops_a: assert property (
        rd_meas && cnt_q != 2'h0 |=> pop_q)
        else $error("measured read did not arm pop");
    other_no_pop_a: assert property (
        first && !rd_meas |=> !pop_q)
        else $error("pop armed by other access");
    rdata_hold_a: assert property (
        !first |=> $stable(avs_readdata_o))
        else $error("read data changed outside a load");
    pos_read_a: assert property (
        avs_read_i && first && avs_address_i == ptc_pkg::OFS_POS
            |=> avs_readdata_o == $past(position_i))
        else $error("position read wrong");

    full_store_c: cover property (cnt_q == 2'h2);
    overflow_c: cover property (ovl_ev);
    pop_push_c: cover property (pop && push);
    sync_cycle_c: cover property (sync_q ##1 !sync_q ##[1:20] sync_q);
    timer_cap_c: cover property (tim_ev && push);
endmodule
`default_nettype wire

// [hdl/ptc_pkg.sv]
// Constants and types shared by the position trigger capture block
package ptc_pkg;
    localparam int unsigned DW = 32;
    localparam int unsigned AW = 5;
    localparam int unsigned DEPTH = 2;
    localparam int unsigned TPW = 16;
    // Register byte offsets
    localparam logic [AW-1:0] OFS_MEAS = 5'h00;
    localparam logic [AW-1:0] OFS_POS = 5'h04;
    localparam logic [AW-1:0] OFS_STAT = 5'h08;
    localparam logic [AW-1:0] OFS_IST = 5'h0C;
    localparam logic [AW-1:0] OFS_IMSK = 5'h10;
    localparam logic [AW-1:0] OFS_CTRL = 5'h14;
    localparam logic [AW-1:0] OFS_TPER = 5'h18;
    // Source bits, shared by entry source field and status register, then status-only overflow and sync bits
    localparam int unsigned SRC_PIN = 0;
    localparam int unsigned SRC_TIM = 1;
    localparam int unsigned SRC_REF = 2;
    localparam int unsigned ST_OVL = 3;
    localparam int unsigned ST_SYNC = 4;
    // Interrupt status and mask bits
    localparam int unsigned IW = 4;
    localparam int unsigned IRQ_CAP = 0;
    localparam int unsigned IRQ_OVL = 1;
    localparam int unsigned IRQ_GAIN = 2;
    localparam int unsigned IRQ_LOST = 3;
    // Control bits
    localparam int unsigned CTRL_PIN_EN = 0;
    localparam int unsigned CTRL_TIM_EN = 1;
    localparam int unsigned CTRL_REF_EN = 2;
    // Reset values
    localparam logic [2:0] CTRL_RST = 3'h5;
    localparam logic [TPW-1:0] TPER_RST = 16'h03E8;
    localparam logic [IW-1:0] IMSK_RST = 4'h0;

    typedef struct packed {
        logic [DW-1:0] value;
        logic [2:0] src;
    } ptc_entry_s;
endpackage

// [verif/ptc_scale_model.sv]
// Scale-side model: live position, trigger pin, reference mark and error strobes
`timescale 1ns/1ps
`default_nettype none
module ptc_scale_model (
    // Clock
    input wire logic clk_i,
    // Commands from the bench
    input wire logic pin_go_i,
    input wire logic ref_go_i,
    input wire logic err_go_i,
    input wire logic [31:0] pos_set_i,
    // Scale and trigger side
    output logic trigger_o,
    output logic ref_mark_o,
    output logic sync_error_o,
    output logic [31:0] position_o
);
    logic [1:0] pin_cnt_q = 2'h0;
    logic ref_q = 1'b0;
    logic err_q = 1'b0;
    logic [31:0] pos_q = 32'h0;
    // Pin stays high three cycles so the three-stage synchroniser cannot miss it
    always @(posedge clk_i) begin
        pin_cnt_q <= pin_go_i ? 2'h3 : pin_cnt_q - {1'b0, |pin_cnt_q};
        ref_q <= ref_go_i;
        err_q <= err_go_i;
        pos_q <= pos_set_i;
    end
    assign trigger_o = |pin_cnt_q;
    assign ref_mark_o = ref_q;
    assign sync_error_o = err_q;
    assign position_o = pos_q;
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Register-level testbench for the position trigger capture block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wrq, trigger_input, refm, err, irq;
    logic go_pin = 1'b0, go_ref = 1'b0, go_err = 1'b0;
    logic f_pin, f_tim, f_ref, f_ovl, f_sync;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0, rdat, pos, pos_set = 32'h0;
    int miscompares = 0, n_tests = 0;
    always #12.5 clk = ~clk;
    ptc_scale_model u_scale (.clk_i(clk), .pin_go_i(go_pin), .ref_go_i(go_ref),
        .err_go_i(go_err), .pos_set_i(pos_set), .trigger_o(trigger_input), .ref_mark_o(refm),
        .sync_error_o(err), .position_o(pos));
    ptc_capture u_dut (.ref_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wrq), .position_i(pos), .ref_mark_i(refm), .sync_error_i(err),
        .trigger_input_i(trigger_input), .pin_trigger_flag_o(f_pin), .timer_trigger_flag_o(f_tim),
        .reference_trigger_flag_o(f_ref), .trigger_overflow_flag_o(f_ovl),
        .reference_sync_flag_o(f_sync), .irq_o(irq));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Holds the request until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk);
        adr <= a; rd <= !w; wr <= w; wd <= d; n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wrq !== 1'b0 && n < 50);
        if (n >= 50) begin
            miscompares++;
            report_and_stop();
        end
        q = rdat;
        rd <= 1'b0; wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    // Bit 0 pin, bit 1 reference mark, bit 2 sync error; position set in the same cycle
    task automatic fire(input logic [2:0] k, input logic [31:0] p);
        @(posedge clk);
        pos_set <= p; go_pin <= k[0]; go_ref <= k[1]; go_err <= k[2];
        @(posedge clk);
        go_pin <= 1'b0; go_ref <= 1'b0; go_err <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        int n;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_chk(ptc_pkg::OFS_STAT, 32'h0, "stat reset");
        rd_chk(ptc_pkg::OFS_CTRL, 32'h5, "ctrl reset");
        rd_chk(ptc_pkg::OFS_TPER, 32'h3E8, "tper reset");
        rd_chk(5'h1C, 32'h0, "unmapped");
        fire(3'h0, 32'h0000_1234);
        rd_chk(ptc_pkg::OFS_MEAS, 32'h0000_1234, "live meas");
        fire(3'h1, 32'h0000_00A1);
        chk("pin flag", 32'h1, {31'h0, f_pin});
        fire(3'h2, 32'h0000_00A2);
        fire(3'h1, 32'h0000_00A3);
        chk("ovl flag", 32'h1, {31'h0, f_ovl});
        chk("sync flag", 32'h1, {31'h0, f_sync});
        rd_chk(ptc_pkg::OFS_STAT, 32'h19, "stat full");
        rd_chk(ptc_pkg::OFS_MEAS, 32'h0000_00A1, "meas first");
        @(posedge clk);
        chk("ref flag", 32'h1, {31'h0, f_ref});
        rd_chk(ptc_pkg::OFS_MEAS, 32'h0000_00A2, "meas second");
        rd_chk(ptc_pkg::OFS_STAT, 32'h10, "stat drained");
        rd_chk(ptc_pkg::OFS_MEAS, 32'h0000_00A3, "meas dropped");
        wr_reg(ptc_pkg::OFS_TPER, 32'h10);
        fire(3'h0, 32'h0000_00B5);
        wr_reg(ptc_pkg::OFS_CTRL, 32'h2);
        n = 0;
        while (f_tim !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk("timer flag", 32'h1, {31'h0, f_tim});
        wr_reg(ptc_pkg::OFS_CTRL, 32'h5);
        rd_chk(ptc_pkg::OFS_MEAS, 32'h0000_00B5, "meas timer");
        @(posedge clk);
        chk("timer popped", 32'h0, {31'h0, f_tim});
        fire(3'h4, 32'h0000_00C1);
        chk("sync lost", 32'h0, {31'h0, f_sync});
        rd_chk(ptc_pkg::OFS_STAT, 32'h0, "stat lost");
        wr_reg(ptc_pkg::OFS_IMSK, 32'h1);
        rd_chk(ptc_pkg::OFS_IST, 32'hF, "ist lost");
        fire(3'h2, 32'h0000_00C2);
        chk("sync again", 32'h1, {31'h0, f_sync});
        chk("irq raised", 32'h1, {31'h0, irq});
        rd_chk(ptc_pkg::OFS_IST, 32'h5, "ist gain");
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr_reg(ptc_pkg::OFS_IMSK, 32'h0);
        fire(3'h1, 32'h0000_00C3);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd_chk(ptc_pkg::OFS_MEAS, 32'h0000_00C2, "meas ref");
        rd_chk(ptc_pkg::OFS_MEAS, 32'h0000_00C3, "meas pin");
        report_and_stop();
    end
    // Tests finish in well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
